// >>> bench/dpf_field.sv
`timescale 1ns/1ps
// far side: fan monitor, input terminals, operator run command, live drive values
module dpf_field (
  // clock
  input wire logic i_clk,
  // levels requested by the bench
  input wire logic [9:0] i_req,
  input wire logic [31:0] i_op,
  // pins toward the block
  output logic [9:0] o_lvl,
  output logic [31:0] o_op
);
  ////////////////////////////////////////////////////////////////////////////
  // pins change just after an edge, like real field wiring
  always_ff @(posedge i_clk)
  begin
    o_lvl <= i_req; // run command, terminals, faults
    o_op <= i_op; // live frequency and current
  end
endmodule : dpf_field

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the protection and fault manager
module tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // shortened counts: 10 cycles a tenth, 3 tenths a usage step
  localparam int unsigned TC = 10;
  localparam int unsigned FS = 3;
  logic clk = 1'b0; // reference clock
  logic rstn = 1'b0; // reset, active low
  logic hsel = 1'b0; // bus select
  logic hwrite = 1'b0; // bus direction
  logic [1:0] htrans = 2'h0; // transfer type
  logic [31:0] haddr = 32'h0; // bus address
  logic [31:0] hwdata = 32'h0; // write data
  logic [9:0] req = 10'h0; // {run,term[4:0],uv,oh,fan_run,fan_fault}
  logic [31:0] op = 32'h0; // {curr,freq}
  logic [9:0] lvl; // field pins
  logic [31:0] opv; // field values
  logic [31:0] hrdata; // read data
  logic hrdy; // bus ready
  logic hresp; // bus response
  logic blk, r1, r2, irq; // drive outputs
  int mismatches = 0; // failed compares
  int n_tests = 0; // compares made
  int seed; // random seed
  logic [63:0] note_q[$]; // {mask, expected}
  string name_q[$]; // what each note checks
  logic [31:0] res; // latest observed result
  event res_ev; // a result appeared

  ////////////////////////////////////////////////////////////////////////////
  // clock, field model, design
  initial
  begin
    forever #5 clk = ~clk;
  end
  dpf_field u_field (.i_clk(clk), .i_req(req), .i_op(op), .o_lvl(lvl), .o_op(opv));
  dpf_top #(.TENTH_CYCLES(TC), .FAN_STEP_TENTHS(FS)) u_dut (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata),
    .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_FAN_FAULT(lvl[0]), .I_FAN_RUN(lvl[1]),
    .I_OVERHEAT(lvl[2]), .I_UNDERVOLT(lvl[3]), .I_TERM(lvl[8:4]), .I_RUN_CMD(lvl[9]),
    .I_OUT_FREQ(opv[15:0]), .I_OUT_CURR(opv[31:16]), .O_OUT_BLOCK(blk), .O_RELAY1(r1),
    .O_RELAY2(r2), .O_IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////
  // watcher: oldest note against each result
  initial
  begin
    logic [63:0] n;
    string nm;
    forever
    begin
      @(res_ev);
      n = note_q.pop_front();
      nm = name_q.pop_front();
      n_tests++;
      if ((res & n[63:32]) !== n[31:0])
      begin
        mismatches++;
        $display("wrong value %s expected %h seen %h", nm, n[31:0], res & n[63:32]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic finish_test;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] m, input logic [31:0] e, input logic [31:0] v);
    note_q.push_back({m, e});
    name_q.push_back(nm);
    res = v;
    ->res_ev;
    #1;
  endtask : chk
  // one single word transfer; holds each phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, m, e, x);
  endtask : rd
  // field levels change at an edge, then settle four cycles
  task automatic drv(input logic [9:0] r);
    @(posedge clk);
    req <= r;
    repeat (4) @(posedge clk);
  endtask : drv
  // {block, relay1, relay2, irq}, sampled clear of the edge
  task automatic outs(input logic [3:0] m, input logic [3:0] e);
    #2;
    chk("outputs", {28'h0, m}, {28'h0, e}, {28'h0, blk, r1, r2, irq});
  endtask : outs

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h1D22_35F2;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // reset values, unmapped place, delay clamp
    rd("usage", dpf_pkg::OFS_FAN_USAGE, 32'hFFFF, 32'h0);
    chk("hresp", 32'h1, 32'h0, {31'h0, hresp});
    rd("threshold", dpf_pkg::OFS_FAN_THRESH, 32'hFFFF, {16'h0, dpf_pkg::FAN_THRESH_RST});
    rd("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
    wr(dpf_pkg::OFS_UV_DELAY, 32'h3FF);
    rd("uv delay", dpf_pkg::OFS_UV_DELAY, 32'h3FF, {22'h0, dpf_pkg::UV_DELAY_MAX});
    outs(4'hF, 4'h0);
    // trip mode fan error; irq masked; terminal 0 resets, terminal 1 blocks
    wr(dpf_pkg::OFS_TERM_FUNC, 32'hA3);
    drv(10'h001);
    outs(4'hF, 4'h8);
    drv(10'h000);
    rd("fan trip", dpf_pkg::OFS_STATUS, 32'h1, 32'h1);
    drv(10'h010);
    drv(10'h000);
    rd("trip clear", dpf_pkg::OFS_STATUS, 32'h7F, 32'h0);
    outs(4'hF, 4'h0);
    // warning mode: relay 1 code 8, relay 2 code 11
    wr(dpf_pkg::OFS_CTRL, 32'h1);
    wr(dpf_pkg::OFS_RELAY_SEL, 32'h0B08);
    drv(10'h001);
    outs(4'hF, 4'h4);
    rd("fan warn", dpf_pkg::OFS_STATUS, 32'h15, 32'h10);
    drv(10'h005);
    outs(4'hC, 4'hC);
    drv(10'h010);
    drv(10'h000);
    outs(4'hF, 4'h0);
    // undervoltage: block and warn at once, trip after 3 tenths
    wr(dpf_pkg::OFS_UV_DELAY, 32'h3);
    wr(dpf_pkg::OFS_IRQ_MASK, 32'h2);
    drv(10'h008);
    outs(4'hF, 4'hA);
    rd("uv early", dpf_pkg::OFS_STATUS, 32'h2, 32'h0);
    repeat (60) @(posedge clk);
    rd("uv trip", dpf_pkg::OFS_STATUS, 32'h2, 32'h2);
    outs(4'hB, 4'hB);
    drv(10'h000);
    outs(4'h3, 4'h1);
    wr(dpf_pkg::OFS_IRQ_STATUS, 32'h1F);
    outs(4'h1, 4'h0);
    drv(10'h010);
    drv(10'h000);
    outs(4'hF, 4'h0);
    // output block terminal, only while running
    op <= $random(seed);
    drv(10'h020);
    outs(4'h8, 4'h0);
    drv(10'h000);
    drv(10'h200);
    drv(10'h220);
    outs(4'h8, 4'h8);
    rd("hold", dpf_pkg::OFS_HOLD, 32'hFFFF_FFFF, op);
    op <= ~op;
    drv(10'h220);
    rd("hold kept", dpf_pkg::OFS_HOLD, 32'hFFFF_FFFF, ~op);
    drv(10'h200);
    outs(4'h8, 4'h8);
    drv(10'h000);
    drv(10'h200);
    outs(4'h8, 4'h0);
    // fan usage against a 0.2 percent threshold, relay 1 code 37
    wr(dpf_pkg::OFS_CTRL, 32'h0);
    wr(dpf_pkg::OFS_FAN_THRESH, 32'h2);
    wr(dpf_pkg::OFS_RELAY_SEL, {24'h0, dpf_pkg::RELAY_FAN_XCHG});
    drv(10'h002);
    repeat (200) @(posedge clk);
    outs(4'h4, 4'h4);
    rd("exchange", dpf_pkg::OFS_STATUS, 32'h20, 32'h20);
    drv(10'h000);
    wr(dpf_pkg::OFS_CTRL, 32'h2);
    rd("usage clear", dpf_pkg::OFS_FAN_USAGE, 32'hFFFF, 32'h0);
    repeat (4) @(posedge clk);
    outs(4'h4, 4'h0);
    finish_test();
  end
endmodule : tb_top

// >>> design/dpf_relay_out.sv
`timescale 1ns/1ps
// one multi-function relay: follows the condition its code selects
module dpf_relay_out (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // selection and conditions
  input wire logic [7:0] i_sel,
  input dpf_pkg::dpf_cond_s i_cond,
  // relay drive
  output logic o_relay
);

  // condition picked by the function code
  wire hit = ((i_sel == dpf_pkg::RELAY_FAN_WARN) && i_cond.fan_warn)
    || ((i_sel == dpf_pkg::RELAY_UNDERVOLT) && i_cond.undervolt)
    || ((i_sel == dpf_pkg::RELAY_FAN_XCHG) && i_cond.fan_xchg);

  // relay tracks condition, drops when it clears
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_relay <= 1'b0;
    else
      o_relay <= hit;
  end

endmodule : dpf_relay_out

// >>> design/dpf_tick.sv
`timescale 1ns/1ps
// counts enabled cycles and pulses once every COUNT of them
module dpf_tick #(
  parameter int unsigned COUNT = 10
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_en,
  input wire logic i_clr,
  // pulse out
  output logic o_tick
);

  localparam int W = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] cnt; // enabled cycles so far
  wire at_last = (cnt == LAST);

  // count, wrap and pulse
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= i_en && at_last && !i_clr;
      if (i_clr || (i_en && at_last))
        cnt <= '0;
      else if (i_en)
        cnt <= cnt + 1'b1;
    end
  end

endmodule : dpf_tick

// >>> design/dpf_top.sv
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Function
// - trip mode fan error blocks output, shows trip
// - warning mode: code 8 relay, keep running
// - overheat blocks output even in warning mode
// - fan usage reaching threshold raises exchange warning
// - usage readable in 0.1 percent, saturating
// - writing one to usage clear zeroes usage
// - dc link undervoltage stops output, low-voltage trip
// - block at once, declare trip after delay
// - code 11 relay warns undervoltage without delay
// - terminal code 5 on while running blocks output
// - hold frequency and current captured at block
// - resume after block off and new run
// - terminal code 3 clears latched trips
module dpf_top #(
  parameter int unsigned TENTH_CYCLES = dpf_pkg::TENTH_CYCLES,
  parameter int unsigned FAN_STEP_TENTHS = dpf_pkg::FAN_STEP_TENTHS
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // fault sources
  input wire logic I_FAN_FAULT,
  input wire logic I_FAN_RUN,
  input wire logic I_OVERHEAT,
  input wire logic I_UNDERVOLT,
  // terminals and operation
  input wire logic [dpf_pkg::NUM_TERM-1:0] I_TERM,
  input wire logic I_RUN_CMD,
  input wire logic [15:0] I_OUT_FREQ,
  input wire logic [15:0] I_OUT_CURR,
  // drive outputs
  output logic O_OUT_BLOCK,
  output logic O_RELAY1,
  output logic O_RELAY2,
  output logic O_IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic dp_valid; // data phase pending
  logic dp_write; // pending is a write
  logic [7:0] dp_addr; // pending byte offset
  wire ap_take = I_HSEL && I_HTRANS[1] && I_HREADY;
  wire [7:0] ap_addr = I_HADDR[7:0];
  wire unused_size = ^I_HSIZE; // whole words only

  // one address phase per transfer, zero wait
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_valid <= ap_take;
      dp_write <= I_HWRITE;
      dp_addr <= ap_addr;
    end
  end

  // data phase write strobes
  wire wr_any = dp_valid && dp_write;
  wire wr_ctrl = wr_any && (dp_addr == dpf_pkg::OFS_CTRL);
  wire wr_relay = wr_any && (dp_addr == dpf_pkg::OFS_RELAY_SEL);
  wire wr_uvd = wr_any && (dp_addr == dpf_pkg::OFS_UV_DELAY);
  wire wr_thr = wr_any && (dp_addr == dpf_pkg::OFS_FAN_THRESH);
  wire wr_term = wr_any && (dp_addr == dpf_pkg::OFS_TERM_FUNC);
  wire wr_istat = wr_any && (dp_addr == dpf_pkg::OFS_IRQ_STATUS);
  wire wr_imask = wr_any && (dp_addr == dpf_pkg::OFS_IRQ_MASK);
  wire usage_clear = wr_ctrl && I_HWDATA[dpf_pkg::CTRL_CLEAR_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // software settings
  logic fan_fault_action; // 0 trip, 1 warning
  logic [7:0] relay1_function_select; // relay 1 code
  logic [7:0] relay2_function_select; // relay 2 code
  logic [9:0] undervoltage_trip_delay; // tenths of a second
  logic [15:0] fan_replace_threshold; // 0.1 % units
  logic [dpf_pkg::NUM_TERM*dpf_pkg::TERM_FIELD_W-1:0] input_terminal_function;
  logic [dpf_pkg::NUM_EVENTS-1:0] irq_mask; // event enables
  wire [9:0] uvd_wr = I_HWDATA[9:0];
  wire [9:0] uvd_lim = (uvd_wr > dpf_pkg::UV_DELAY_MAX) ? dpf_pkg::UV_DELAY_MAX : uvd_wr;

  // settings writes
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      fan_fault_action <= 1'b0;
      relay1_function_select <= dpf_pkg::RELAY_SEL_RST;
      relay2_function_select <= dpf_pkg::RELAY_SEL_RST;
      undervoltage_trip_delay <= dpf_pkg::UV_DELAY_RST;
      fan_replace_threshold <= dpf_pkg::FAN_THRESH_RST;
      input_terminal_function <= '0;
      irq_mask <= '0;
    end
    else
    begin
      if (wr_ctrl)
        fan_fault_action <= I_HWDATA[dpf_pkg::CTRL_ACTION_BIT];
      if (wr_relay)
      begin
        relay1_function_select <= I_HWDATA[7:0];
        relay2_function_select <= I_HWDATA[dpf_pkg::RELAY2_LSB +: 8];
      end
      if (wr_uvd)
        undervoltage_trip_delay <= uvd_lim;
      if (wr_thr)
        fan_replace_threshold <= I_HWDATA[15:0];
      if (wr_term)
        input_terminal_function <= I_HWDATA[dpf_pkg::NUM_TERM*dpf_pkg::TERM_FIELD_W-1:0];
      if (wr_imask)
        irq_mask <= I_HWDATA[dpf_pkg::NUM_EVENTS-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // terminal decode
  logic [dpf_pkg::NUM_TERM-1:0] term_block; // terminal set to block
  logic [dpf_pkg::NUM_TERM-1:0] term_reset; // terminal set to reset
  genvar g;
  generate
    for (g = 0; g < dpf_pkg::NUM_TERM; g++)
    begin : g_term
      wire [4:0] code = input_terminal_function[g*dpf_pkg::TERM_FIELD_W +: dpf_pkg::TERM_FIELD_W];
      assign term_block[g] = I_TERM[g] && (code == dpf_pkg::TERM_OUT_BLOCK);
      assign term_reset[g] = I_TERM[g] && (code == dpf_pkg::TERM_TRIP_RESET);
    end
  endgenerate
  wire block_in = |term_block; // output_block_input asserted
  wire trip_reset = |term_reset;

  //////////////////////////////////////////////////////////////////////////////
  // time base and fan usage steps
  logic tenth; // 0.1 s pulse
  logic fan_step; // one 0.1 % of fan life
  dpf_tick #(.COUNT(TENTH_CYCLES)) u_tenth (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_en(1'b1),
    .i_clr(1'b0),
    .o_tick(tenth)
  );
  dpf_tick #(.COUNT(FAN_STEP_TENTHS)) u_fan_step (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_en(tenth && I_FAN_RUN),
    .i_clr(usage_clear),
    .o_tick(fan_step)
  );

  //////////////////////////////////////////////////////////////////////////////
  // fan usage accounting
  logic [15:0] fan_usage_percent; // 0.1 % units
  wire usage_full = (fan_usage_percent == dpf_pkg::USAGE_MAX);
  wire fan_xchg = (fan_usage_percent >= fan_replace_threshold);

  // count up, saturate, clear on request
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      fan_usage_percent <= 16'h0000;
    else if (usage_clear)
      fan_usage_percent <= 16'h0000;
    else if (fan_step && !usage_full)
      fan_usage_percent <= fan_usage_percent + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // undervoltage delay and trips
  logic [9:0] uv_cnt; // tenths spent under voltage
  logic uv_trip; // low voltage trip declared
  logic fan_trip; // fan trip latched
  logic oh_trip; // overheat trip latched
  wire uv_due = I_UNDERVOLT && (uv_cnt >= undervoltage_trip_delay);
  wire fan_trip_set = I_FAN_FAULT && !fan_fault_action;
  wire fan_warn = I_FAN_FAULT && fan_fault_action;

  // delay counter runs only while under voltage
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      uv_cnt <= 10'h000;
    else if (!I_UNDERVOLT)
      uv_cnt <= 10'h000;
    else if (tenth && (uv_cnt != dpf_pkg::UV_DELAY_MAX))
      uv_cnt <= uv_cnt + 10'h001;
  end

  // latched trips, a new cause beats the reset terminal
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      uv_trip <= 1'b0;
      fan_trip <= 1'b0;
      oh_trip <= 1'b0;
    end
    else
    begin
      uv_trip <= uv_due || (uv_trip && !trip_reset);
      fan_trip <= fan_trip_set || (fan_trip && !trip_reset);
      oh_trip <= I_OVERHEAT || (oh_trip && !trip_reset);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output block by terminal
  logic run_d; // run command last cycle
  logic bx_lock; // output held off by block input
  dpf_pkg::dpf_hold_s hold; // values at block moment
  wire run_rise = I_RUN_CMD && !run_d;
  wire bx_set = block_in && I_RUN_CMD && !bx_lock;
  wire bx_release = !block_in && run_rise;

  // lock, release and snapshot
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      run_d <= 1'b0;
      bx_lock <= 1'b0;
      hold <= '0;
    end
    else
    begin
      run_d <= I_RUN_CMD;
      if (bx_set)
      begin
        bx_lock <= 1'b1;
        hold <= '{curr: I_OUT_CURR, freq: I_OUT_FREQ};
      end
      else if (bx_release)
        bx_lock <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output block and relays
  wire next_out_block = fan_trip_set || fan_trip || I_OVERHEAT || oh_trip
    || I_UNDERVOLT || uv_trip || bx_set || bx_lock;

  // power stage block, registered
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_OUT_BLOCK <= 1'b0;
    else
      O_OUT_BLOCK <= next_out_block;
  end

  // relay conditions, undervolt straight from the input
  wire dpf_pkg::dpf_cond_s cond = '{fan_warn: fan_warn, undervolt: I_UNDERVOLT, fan_xchg: fan_xchg};

  dpf_relay_out u_relay1 (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_sel(relay1_function_select),
    .i_cond(cond),
    .o_relay(O_RELAY1)
  );
  dpf_relay_out u_relay2 (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_sel(relay2_function_select),
    .i_cond(cond),
    .o_relay(O_RELAY2)
  );

  //////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [dpf_pkg::NUM_EVENTS-1:0] irq_status; // sticky events
  logic xchg_d; // exchange level last cycle
  wire oh_set = I_OVERHEAT && !oh_trip; // first cycle of a new overheat
  wire [dpf_pkg::NUM_EVENTS-1:0] events = {oh_set, bx_set, fan_xchg && !xchg_d,
    uv_due && !uv_trip, fan_trip_set && !fan_trip};
  wire [dpf_pkg::NUM_EVENTS-1:0] w1c = wr_istat ? I_HWDATA[dpf_pkg::NUM_EVENTS-1:0] : '0;

  // set wins over a write-one clear
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      irq_status <= '0;
      xchg_d <= 1'b0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~w1c) | events;
      xchg_d <= fan_xchg;
      O_IRQ <= |(((irq_status & ~w1c) | events) & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data
  wire [7:0] status = {1'b0, oh_trip, fan_xchg, fan_warn, bx_lock, O_OUT_BLOCK, uv_trip, fan_trip};
  logic [31:0] rd_mux; // selected register

  // read select, unmapped reads zero
  always_comb
  begin
    unique case (ap_addr)
      dpf_pkg::OFS_CTRL: rd_mux = {31'h0000_0000, fan_fault_action};
      dpf_pkg::OFS_RELAY_SEL: rd_mux = {16'h0000, relay2_function_select, relay1_function_select};
      dpf_pkg::OFS_UV_DELAY: rd_mux = {22'h00_0000, undervoltage_trip_delay};
      dpf_pkg::OFS_FAN_THRESH: rd_mux = {16'h0000, fan_replace_threshold};
      dpf_pkg::OFS_FAN_USAGE: rd_mux = {16'h0000, fan_usage_percent};
      dpf_pkg::OFS_TERM_FUNC: rd_mux = {7'h00, input_terminal_function};
      dpf_pkg::OFS_STATUS: rd_mux = {24'h00_0000, status};
      dpf_pkg::OFS_HOLD: rd_mux = hold;
      dpf_pkg::OFS_IRQ_STATUS: rd_mux = {27'h000_0000, irq_status};
      dpf_pkg::OFS_IRQ_MASK: rd_mux = {27'h000_0000, irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered in the address phase
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_HRDATA <= 32'h0000_0000;
    else if (ap_take && !I_HWRITE)
      O_HRDATA <= rd_mux;
  end

  assign O_HREADYOUT = 1'b1 | unused_size; // zero wait states
  assign O_HRESP = 1'b0; // always okay

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  fan_trip_block_a: assert property (fan_trip_set |=> O_OUT_BLOCK && fan_trip)
    else $error("fan fault in trip mode did not block output");
  fan_warn_relay_a: assert property ((relay1_function_select == dpf_pkg::RELAY_FAN_WARN) && fan_warn
    && $stable(relay1_function_select) |=> O_RELAY1)
    else $error("fan warning relay not asserted");
  overheat_block_a: assert property (I_OVERHEAT |=> O_OUT_BLOCK [*2])
    else $error("overheat did not block output");
  fan_exchange_a: assert property ((relay1_function_select == dpf_pkg::RELAY_FAN_XCHG) && fan_xchg
    && $stable(relay1_function_select) |=> O_RELAY1)
    else $error("fan exchange warning missing");
  usage_sat_a: assert property (usage_full && !usage_clear |=> usage_full)
    else $error("fan usage wrapped past full scale");
  usage_clear_a: assert property (usage_clear |=> fan_usage_percent == 16'h0000)
    else $error("fan usage not cleared");
  uv_block_a: assert property (I_UNDERVOLT |=> O_OUT_BLOCK)
    else $error("undervoltage did not block output at once");
  uv_trip_delay_a: assert property ($rose(uv_trip) |-> $past(I_UNDERVOLT)
    && ($past(uv_cnt) >= $past(undervoltage_trip_delay)))
    else $error("low voltage trip declared before its delay");
  uv_warn_a: assert property ((relay2_function_select == dpf_pkg::RELAY_UNDERVOLT) && I_UNDERVOLT
    && $stable(relay2_function_select) |=> O_RELAY2)
    else $error("undervoltage relay delayed");
  bx_block_a: assert property (block_in && I_RUN_CMD |=> bx_lock ##0 O_OUT_BLOCK)
    else $error("block input did not block output");
  bx_hold_a: assert property (bx_lock && $past(bx_lock) |-> $stable(hold))
    else $error("captured values changed during block");
  bx_resume_a: assert property (bx_lock && !(!block_in && run_rise) |=> bx_lock)
    else $error("block released without new run command");
  trip_clear_a: assert property (trip_reset && !I_FAN_FAULT && !I_OVERHEAT |=> !fan_trip && !oh_trip)
    else $error("reset terminal did not clear trips");
  relay_follow_a: assert property ((relay2_function_select == dpf_pkg::RELAY_UNDERVOLT)
    && !I_UNDERVOLT |=> !O_RELAY2)
    else $error("relay did not drop with its condition");

endmodule : dpf_top

// >>> pkg/dpf_pkg.sv
package dpf_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // fault action, usage clear
  localparam logic [7:0] OFS_RELAY_SEL = 8'h04; // relay function codes
  localparam logic [7:0] OFS_UV_DELAY = 8'h08; // undervoltage delay, tenths of s
  localparam logic [7:0] OFS_FAN_THRESH = 8'h0C; // replace threshold, 0.1 %
  localparam logic [7:0] OFS_FAN_USAGE = 8'h10; // usage, 0.1 %, read only
  localparam logic [7:0] OFS_TERM_FUNC = 8'h14; // five terminal function codes
  localparam logic [7:0] OFS_STATUS = 8'h18; // live state, read only
  localparam logic [7:0] OFS_HOLD = 8'h1C; // captured freq and current
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20; // sticky events, write one clears
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24; // interrupt enables

  //////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int CTRL_ACTION_BIT = 0; // fan fault action
  localparam int CTRL_CLEAR_BIT = 1; // fan usage clear strobe
  localparam int RELAY2_LSB = 8; // relay 2 code field
  localparam int TERM_FIELD_W = 5; // width of one terminal code
  localparam int NUM_TERM = 5; // input terminals
  localparam int NUM_EVENTS = 5; // interrupt sources
  localparam logic [15:0] FAN_THRESH_RST = 16'h0384; // 90.0 %
  localparam logic [9:0] UV_DELAY_RST = 10'h000; // 0.0 s
  localparam logic [9:0] UV_DELAY_MAX = 10'h0258; // 60.0 s in tenths
  localparam logic [7:0] RELAY_SEL_RST = 8'h00; // no function
  localparam logic [15:0] USAGE_MAX = 16'hFFFF; // 6553.5 %

  //////////////////////////////////////////////////////////////////////////////
  // function codes
  localparam logic [7:0] RELAY_FAN_WARN = 8'h08; // fan error warning
  localparam logic [7:0] RELAY_UNDERVOLT = 8'h0B; // undervoltage warning
  localparam logic [7:0] RELAY_FAN_XCHG = 8'h25; // fan exchange warning
  localparam logic [4:0] TERM_TRIP_RESET = 5'h03; // clear latched trips
  localparam logic [4:0] TERM_OUT_BLOCK = 5'h05; // output block input

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10; // 100 MHz
  localparam int TENTH_MS = 100; // base tick of 0.1 s
  localparam int TENTH_CYCLES = TENTH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAN_LIFE_HOURS = 50000; // rated fan lifetime
  localparam int FAN_STEP_TENTHS = FAN_LIFE_HOURS * 3600 * 10 / 1000; // one 0.1 % step

  //////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic fan_warn; // fan error in warning mode
    logic undervolt; // dc link below level
    logic fan_xchg; // usage reached threshold
  } dpf_cond_s;

  typedef struct packed {
    logic [15:0] curr; // output current at block
    logic [15:0] freq; // output frequency at block
  } dpf_hold_s;

endpackage : dpf_pkg
